// [hdl/osc_pkg.sv]
// constants, types and helpers shared by the oscillator control block
package osc_pkg;

    // register port and synchroniser geometry
    localparam int ADDR_W = 4;
    localparam int DATA_W = 16;
    localparam int SYNC_W = 3;

    // word addresses on the register port
    localparam logic [3:0] CTRL_ADDR = 4'h0;
    localparam logic [3:0] DIV_ADDR = 4'h1;
    localparam logic [3:0] UNLOCK_ADDR = 4'h2;

    // field positions in the oscillator control word
    localparam int CUR_LSB = 12;
    localparam int NEXT_LSB = 8;
    localparam int FREEZE_BIT = 7;
    localparam int PIN_BIT = 6;
    localparam int LOCK_BIT = 5;
    localparam int CF_BIT = 3;
    localparam int PSR_BIT = 2;
    localparam int LSC_BIT = 1;
    localparam int SWR_BIT = 0;

    // field positions in the clock divider word
    localparam int POST_LSB = 6;
    localparam int PLL_ENABLE_BIT = 5;

    // oscillator source codes
    localparam logic [2:0] SRC_FRC = 3'h0;
    localparam logic [2:0] SRC_FRCPLL = 3'h1;
    localparam logic [2:0] SRC_PRI = 3'h2;
    localparam logic [2:0] SRC_PRIPLL = 3'h3;
    localparam logic [2:0] SRC_LSC = 3'h4;
    localparam logic [2:0] SRC_LOW_POWER_INTERNAL_RC = 3'h5;
    localparam logic [2:0] SRC_RSVD = 3'h6;
    localparam logic [2:0] SRC_FRCDIV = 3'h7;

    // values after reset
    localparam logic [2:0] SRC_RST = 3'h0;
    localparam logic [1:0] POST_RST = 2'h0;
    localparam logic BIT_RST = 1'b0;
    localparam logic [15:0] RDATA_RST = 16'h0000;

    // unlock keys, values arbitrary
    localparam logic [15:0] UNLOCK_KEY1 = 16'h3C5A;
    localparam logic [15:0] UNLOCK_KEY2 = 16'hA5C3;
    // cycles the unlock stays open after the second key
    localparam logic [3:0] UNLOCK_WINDOW_CYC = 4'h8;

    // unlock sequence states
    typedef enum logic [1:0] {OSC_KEY_IDLE, OSC_KEY_HALF, OSC_KEY_OPEN} osc_key_e;
    // clock switch states
    typedef enum logic {OSC_SW_IDLE, OSC_SW_BUSY} osc_sw_e;

    // true for the two sources that run through the pll
    function automatic logic osc_is_pll_source(input logic [2:0] src);
        return (src == SRC_FRCPLL) || (src == SRC_PRIPLL);
    endfunction

endpackage

// [hdl/osc_sync2.sv]
// two flip-flop synchroniser for the asynchronous status inputs
`timescale 1ns/1ps
module osc_sync2 (
    input wire logic clk,
    input wire logic reset,
    input wire logic [osc_pkg::SYNC_W-1:0] async_in,
    output logic [osc_pkg::SYNC_W-1:0] sync_out
);

    // first stage, read only by the second stage
    logic [osc_pkg::SYNC_W-1:0] meta_q;
    // second stage, safe for logic
    logic [osc_pkg::SYNC_W-1:0] sync_q;

    // both stages clear on reset and shift every edge
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            meta_q <= 3'h0;
            sync_q <= 3'h0;
        end else begin
            meta_q <= async_in;
            sync_q <= meta_q;
        end
    end

    assign sync_out = sync_q;

endmodule

// [hdl/osc_ctrl.sv]
// oscillator control register with write lock, switch tracking and status
`timescale 1ns/1ps
module osc_ctrl (
    input wire logic clk,
    input wire logic reset,
    input wire logic [3:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [15:0] reg_rdata,
    input wire logic [2:0] initial_source_fuses,
    input wire logic one_way_pin_freeze_fuse,
    input wire logic fail_safe_monitor_enable,
    input wire logic pll_in_lock,
    input wire logic pll_startup_done,
    input wire logic fail_safe_monitor_fail,
    input wire logic sleep_mode,
    input wire logic switch_done,
    output logic switch_start,
    output logic [2:0] switch_target,
    output logic [2:0] current_source,
    output logic primary_osc_run,
    output logic low_speed_crystal_on,
    output logic [1:0] system_clock_postscaler,
    output logic pll_enable,
    output logic pin_map_frozen,
    output logic clock_select_frozen
);

    // synchronised status inputs
    logic [2:0] status_s;
    logic pll_ok_s;
    logic clock_fail_s;

    // register state
    logic init_done_q;
    logic [2:0] current_source_q;
    logic [2:0] next_source_q;
    logic clock_select_freeze_q;
    logic pin_map_freeze_q;
    logic lock_status_q;
    logic clock_fail_flag_q;
    logic primary_sleep_run_q;
    logic low_speed_crystal_enable_q;
    logic [1:0] postscaler_q;
    logic pll_enable_q;
    logic [15:0] rdata_q;
    logic primary_run_q;

    // switch tracking
    osc_pkg::osc_sw_e sw_state_q;
    osc_pkg::osc_sw_e sw_state_d;
    logic [2:0] switch_target_q;
    logic switch_start_q;

    // unlock sequence
    osc_pkg::osc_key_e key_state_q;
    osc_pkg::osc_key_e key_state_d;
    logic [3:0] window_q;
    logic [3:0] window_d;

    // decode wires
    logic wr_ctrl;
    logic wr_ctrl_ok;
    logic wr_div;
    logic wr_div_ok;
    logic wr_key;
    logic freeze_eff;
    logic unlock_open;
    logic start_req;
    logic start_ok;
    logic switch_request;
    logic lock_d;
    logic clock_fail_d;
    logic pin_map_d;
    logic freeze_d;
    logic [2:0] next_source_d;
    logic [15:0] ctrl_word;
    logic [15:0] div_word;
    logic [15:0] unlock_word;
    logic [15:0] rdata_d;

    // pll lock, start-up timer and failure come from other clock domains
    osc_sync2 u_sync (
        .clk(clk),
        .reset(reset),
        .async_in({fail_safe_monitor_fail, pll_startup_done, pll_in_lock}),
        .sync_out(status_s)
    );

    assign pll_ok_s = status_s[0] | status_s[1];
    assign clock_fail_s = status_s[2];

    // bus decode; control and divider writes are not taken before the fuses are loaded, key writes are
    assign wr_ctrl = reg_write && (reg_addr == osc_pkg::CTRL_ADDR) && init_done_q;
    assign unlock_open = (key_state_q == osc_pkg::OSC_KEY_OPEN);
    assign wr_ctrl_ok = wr_ctrl && unlock_open;
    assign wr_div = reg_write && (reg_addr == osc_pkg::DIV_ADDR) && init_done_q;
    assign wr_key = reg_write && (reg_addr == osc_pkg::UNLOCK_ADDR);

    // freeze only bites while the fail-safe monitor is enabled
    assign freeze_eff = clock_select_freeze_q && fail_safe_monitor_enable;
    assign wr_div_ok = wr_div && !freeze_eff;

    // unlock sequence: two keys back to back, then a short window
    always_comb begin
        key_state_d = key_state_q;
        window_d = window_q;
        unique case (key_state_q)
            osc_pkg::OSC_KEY_IDLE: begin
                // wait for the first key
                if (wr_key && (reg_wdata == osc_pkg::UNLOCK_KEY1)) begin
                    key_state_d = osc_pkg::OSC_KEY_HALF;
                end
            end
            osc_pkg::OSC_KEY_HALF: begin
                // second key opens, anything else written to keys aborts
                if (wr_key && (reg_wdata == osc_pkg::UNLOCK_KEY2)) begin
                    key_state_d = osc_pkg::OSC_KEY_OPEN;
                    window_d = osc_pkg::UNLOCK_WINDOW_CYC;
                end else if (wr_key || wr_ctrl) begin
                    key_state_d = osc_pkg::OSC_KEY_IDLE;
                end
            end
            osc_pkg::OSC_KEY_OPEN: begin
                // one control write consumes the unlock; window runs out too
                if (wr_ctrl || (window_q == 4'h1)) begin
                    key_state_d = osc_pkg::OSC_KEY_IDLE;
                    window_d = 4'h0;
                end else if (wr_key) begin
                    key_state_d = (reg_wdata == osc_pkg::UNLOCK_KEY1) ? osc_pkg::OSC_KEY_HALF
                                                                      : osc_pkg::OSC_KEY_IDLE;
                    window_d = 4'h0;
                end else begin
                    window_d = window_q - 4'h1;
                end
            end
        endcase
    end

    // unlock state registers
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            key_state_q <= osc_pkg::OSC_KEY_IDLE;
            window_q <= 4'h0;
        end else begin
            key_state_q <= key_state_d;
            window_q <= window_d;
        end
    end

    // a switch request needs unlock, no freeze, and an idle tracker
    assign start_req = wr_ctrl_ok && !freeze_eff && reg_wdata[osc_pkg::SWR_BIT];
    // the reserved code never starts a switch
    assign start_ok = start_req && (sw_state_q == osc_pkg::OSC_SW_IDLE)
                      && (reg_wdata[osc_pkg::NEXT_LSB +: 3] != osc_pkg::SRC_RSVD);

    // switch tracker: busy from start until the sequencer reports done
    always_comb begin
        sw_state_d = sw_state_q;
        unique case (sw_state_q)
            osc_pkg::OSC_SW_IDLE: begin
                if (start_ok) begin
                    sw_state_d = osc_pkg::OSC_SW_BUSY;
                end
            end
            osc_pkg::OSC_SW_BUSY: begin
                if (switch_done) begin
                    sw_state_d = osc_pkg::OSC_SW_IDLE;
                end
            end
        endcase
    end

    // the request bit reads high for as long as the switch runs
    assign switch_request = (sw_state_q == osc_pkg::OSC_SW_BUSY);

    // switch tracker registers; current source loads the fuses, then moves only on completion
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            sw_state_q <= osc_pkg::OSC_SW_IDLE;
            switch_target_q <= osc_pkg::SRC_RST;
            switch_start_q <= osc_pkg::BIT_RST;
            current_source_q <= osc_pkg::SRC_RST;
        end else begin
            sw_state_q <= sw_state_d;
            switch_start_q <= start_ok;
            if (start_ok) begin
                switch_target_q <= reg_wdata[osc_pkg::NEXT_LSB +: 3];
            end
            if (!init_done_q) begin
                current_source_q <= initial_source_fuses;
            end else if (switch_request && switch_done) begin
                current_source_q <= switch_target_q;
            end
        end
    end

    // next source field: fuse value first, then unfrozen unlocked writes
    assign next_source_d = !init_done_q ? initial_source_fuses :
                           (wr_ctrl_ok && !freeze_eff) ? reg_wdata[osc_pkg::NEXT_LSB +: 3] :
                           next_source_q;

    // lock status is dropped in non-pll modes and while a switch runs
    assign lock_d = osc_pkg::osc_is_pll_source(current_source_q) && !switch_request && !start_ok
                    && pll_ok_s;

    // failure flag: hardware set beats a software clear of the same cycle
    assign clock_fail_d = clock_fail_s ? 1'b1 :
                          (wr_ctrl_ok && !reg_wdata[osc_pkg::CF_BIT]) ? 1'b0 :
                          clock_fail_flag_q;

    // pin freeze: unlocked writes only; one-way fuse keeps a set bit set
    assign pin_map_d = wr_ctrl_ok ? (reg_wdata[osc_pkg::PIN_BIT] | (one_way_pin_freeze_fuse & pin_map_freeze_q))
                                  : pin_map_freeze_q;

    // clock freeze cannot be released while it is in force
    assign freeze_d = wr_ctrl_ok ? (reg_wdata[osc_pkg::FREEZE_BIT] | freeze_eff) : clock_select_freeze_q;

    // control word fields
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            init_done_q <= osc_pkg::BIT_RST;
            next_source_q <= osc_pkg::SRC_RST;
            clock_select_freeze_q <= osc_pkg::BIT_RST;
            pin_map_freeze_q <= osc_pkg::BIT_RST;
            lock_status_q <= osc_pkg::BIT_RST;
            clock_fail_flag_q <= osc_pkg::BIT_RST;
            primary_sleep_run_q <= osc_pkg::BIT_RST;
            low_speed_crystal_enable_q <= osc_pkg::BIT_RST;
        end else begin
            init_done_q <= 1'b1;
            next_source_q <= next_source_d;
            clock_select_freeze_q <= freeze_d;
            pin_map_freeze_q <= pin_map_d;
            lock_status_q <= lock_d;
            clock_fail_flag_q <= clock_fail_d;
            if (wr_ctrl_ok) begin
                primary_sleep_run_q <= reg_wdata[osc_pkg::PSR_BIT];
                low_speed_crystal_enable_q <= reg_wdata[osc_pkg::LSC_BIT];
            end
        end
    end

    // divider word fields, blocked by the clock freeze
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            postscaler_q <= osc_pkg::POST_RST;
            pll_enable_q <= osc_pkg::BIT_RST;
        end else if (wr_div_ok) begin
            postscaler_q <= reg_wdata[osc_pkg::POST_LSB +: 2];
            pll_enable_q <= reg_wdata[osc_pkg::PLL_ENABLE_BIT];
        end
    end

    // primary oscillator runs when awake, or asleep if allowed
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            primary_run_q <= 1'b1;
        end else begin
            primary_run_q <= !sleep_mode || primary_sleep_run_q;
        end
    end

    // read words; unused positions are zero
    assign ctrl_word = {1'b0, current_source_q, 1'b0, next_source_q, clock_select_freeze_q, pin_map_freeze_q,
                        lock_status_q, 1'b0, clock_fail_flag_q, primary_sleep_run_q,
                        low_speed_crystal_enable_q, switch_request};
    assign div_word = {8'h00, postscaler_q, pll_enable_q, 5'h00};
    assign unlock_word = {15'h0000, unlock_open};

    // read mux; unmapped addresses read zero
    assign rdata_d = !reg_read ? 16'h0000 :
                     (reg_addr == osc_pkg::CTRL_ADDR) ? ctrl_word :
                     (reg_addr == osc_pkg::DIV_ADDR) ? div_word :
                     (reg_addr == osc_pkg::UNLOCK_ADDR) ? unlock_word :
                     16'h0000;

    // read data stand for exactly the cycle after the strobe
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            rdata_q <= osc_pkg::RDATA_RST;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    // outputs
    assign reg_rdata = rdata_q;
    assign switch_start = switch_start_q;
    assign switch_target = switch_target_q;
    assign current_source = current_source_q;
    assign primary_osc_run = primary_run_q;
    assign low_speed_crystal_on = low_speed_crystal_enable_q;
    assign system_clock_postscaler = postscaler_q;
    assign pll_enable = pll_enable_q;
    assign pin_map_frozen = pin_map_freeze_q;
    assign clock_select_frozen = freeze_eff;

    // lock reads one a cycle after a settled pll mode with a locked pll
    property p_lock_set;
        @(posedge clk) disable iff (reset)
        (osc_pkg::osc_is_pll_source(current_source_q) && !switch_request && !start_ok && pll_ok_s)
        |=> lock_status_q;
    endproperty
    a_lock_set: assert property (p_lock_set) else $error("lock bit not set");

    // lock reads zero in non-pll modes and during a switch
    property p_lock_clear;
        @(posedge clk) disable iff (reset)
        (!osc_pkg::osc_is_pll_source(current_source_q) || switch_request) |=> !lock_status_q;
    endproperty
    a_lock_clear: assert property (p_lock_clear) else $error("lock bit not cleared");

    // a detected failure is flagged next cycle even against a clear
    property p_fail_flag;
        @(posedge clk) disable iff (reset)
        clock_fail_s |=> clock_fail_flag_q;
    endproperty
    a_fail_flag: assert property (p_fail_flag) else $error("failure flag missed");

    // primary run output follows sleep and the sleep-run bit
    property p_primary_sleep;
        @(posedge clk) disable iff (reset)
        (sleep_mode && !primary_sleep_run_q) |=> !primary_osc_run;
    endproperty
    a_primary_sleep: assert property (p_primary_sleep) else $error("primary not stopped asleep");

    // a completed switch drops the request bit and moves the current source
    property p_switch_done;
        @(posedge clk) disable iff (reset)
        (switch_request && switch_done) |=> (!switch_request && (current_source_q == $past(switch_target_q)));
    endproperty
    a_switch_done: assert property (p_switch_done) else $error("switch completion wrong");

    // a frozen clock selection ignores writes to the guarded fields
    property p_freeze;
        @(posedge clk) disable iff (reset)
        (freeze_eff && (wr_ctrl || wr_div)) |=> ($stable(next_source_q) && $stable(postscaler_q)
                                                && $stable(pll_enable_q) && !switch_start_q);
    endproperty
    a_freeze: assert property (p_freeze) else $error("frozen field changed");

    // writes without unlock leave the control word alone
    property p_write_lock;
        @(posedge clk) disable iff (reset)
        (wr_ctrl && !unlock_open && !clock_fail_s) |=> ($stable(next_source_q) && $stable(pin_map_freeze_q)
                                                       && $stable(primary_sleep_run_q) && !switch_start_q);
    endproperty
    a_write_lock: assert property (p_write_lock) else $error("locked write took effect");

    // with the one-way fuse a set pin freeze stays set
    property p_one_way;
        @(posedge clk) disable iff (reset)
        (one_way_pin_freeze_fuse && pin_map_freeze_q) |=> pin_map_freeze_q;
    endproperty
    a_one_way: assert property (p_one_way) else $error("pin freeze cleared");

    // both source fields hold the fuse value right after reset
    property p_fuse_load;
        @(posedge clk) disable iff (reset)
        !init_done_q |=> ((current_source_q == $past(initial_source_fuses))
                          && (next_source_q == $past(initial_source_fuses)));
    endproperty
    a_fuse_load: assert property (p_fuse_load) else $error("fuse value not loaded");

    // unused positions of the control word read zero
    property p_unused_zero;
        @(posedge clk) disable iff (reset)
        (reg_read && (reg_addr == osc_pkg::CTRL_ADDR)) |=> (!reg_rdata[11] && !reg_rdata[4] && !reg_rdata[15]);
    endproperty
    a_unused_zero: assert property (p_unused_zero) else $error("unused bit not zero");

    // the reserved source never launches a switch
    property p_no_reserved;
        @(posedge clk) disable iff (reset)
        switch_start_q |-> (switch_target_q != osc_pkg::SRC_RSVD);
    endproperty
    a_no_reserved: assert property (p_no_reserved) else $error("reserved source started");

    // the crystal enable output follows an accepted write
    property p_crystal;
        @(posedge clk) disable iff (reset)
        wr_ctrl_ok |=> (low_speed_crystal_on == $past(reg_wdata[osc_pkg::LSC_BIT]));
    endproperty
    a_crystal: assert property (p_crystal) else $error("crystal enable wrong");

endmodule

// [tb/tb_oscillator_control_register.sv]
// self-checking testbench for the oscillator control register
`timescale 1ns/1ps
module tb_oscillator_control_register;
    logic clk, reset, reg_write, reg_read, one_way_pin_freeze_fuse, fail_safe_monitor_enable;
    logic pll_in_lock, pll_startup_done, fail_safe_monitor_fail, sleep_mode, switch_done;
    logic [3:0] reg_addr; // word address
    logic [15:0] reg_wdata, reg_rdata, rd; // bus data and last read word
    logic [2:0] initial_source_fuses, switch_target, current_source;
    logic switch_start, primary_osc_run, low_speed_crystal_on, pll_enable, pin_map_frozen, clock_select_frozen;
    logic [1:0] system_clock_postscaler;
    int err_count = 0; // mismatches seen
    int n_tests = 0; // comparisons made
    int n_starts = 0; // switch start pulses seen

    osc_ctrl osc_ctrl_inst (.clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
        .initial_source_fuses(initial_source_fuses), .one_way_pin_freeze_fuse(one_way_pin_freeze_fuse),
        .fail_safe_monitor_enable(fail_safe_monitor_enable), .pll_in_lock(pll_in_lock),
        .pll_startup_done(pll_startup_done), .fail_safe_monitor_fail(fail_safe_monitor_fail),
        .sleep_mode(sleep_mode), .switch_done(switch_done), .switch_start(switch_start),
        .switch_target(switch_target), .current_source(current_source), .primary_osc_run(primary_osc_run),
        .low_speed_crystal_on(low_speed_crystal_on), .system_clock_postscaler(system_clock_postscaler),
        .pll_enable(pll_enable), .pin_map_frozen(pin_map_frozen), .clock_select_frozen(clock_select_frozen));

    // 25 MHz clock
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // counts cycles in which a switch start pulse stands
    always @(posedge clk) begin
        if (switch_start === 1'b1) n_starts <= n_starts + 1;
    end

    // compares one value, reports a mismatch
    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        n_tests++;
        if (got !== exp) begin
            $display("Error %s expected %h seen %h", name, exp, got);
            err_count++;
        end
    endtask

    // waits n rising edges, then lets their updates land
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // one-cycle write strobe
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clk);
        reg_write <= 1'b0;
    endtask

    // one-cycle read strobe, data taken in the following cycle
    task automatic rdchk(input string name, input logic [3:0] a, input logic [15:0] exp);
        @(posedge clk);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clk);
        reg_read <= 1'b0;
        #1 rd = reg_rdata;
        chk(name, exp, rd);
    endtask

    // key pair then a guarded control write
    task automatic uwr(input logic [15:0] d);
        wr(osc_pkg::UNLOCK_ADDR, osc_pkg::UNLOCK_KEY1);
        wr(osc_pkg::UNLOCK_ADDR, osc_pkg::UNLOCK_KEY2);
        wr(osc_pkg::CTRL_ADDR, d);
    endtask

    // one completion pulse from the sequencer
    task automatic done_pulse();
        @(posedge clk);
        switch_done <= 1'b1;
        @(posedge clk);
        switch_done <= 1'b0;
        cyc(6);
    endtask

    // fuse-loaded sources, unused bits, unmapped and divider reads
    task automatic t_reset();
        rdchk("ctrl after reset", osc_pkg::CTRL_ADDR, 16'h3300);
        rdchk("unmapped", 4'hF, 16'h0000);
        rdchk("divider after reset", osc_pkg::DIV_ADDR, 16'h0000);
        $display("done reset");
    endtask

    // writes without the key pair change nothing
    task automatic t_lock();
        wr(osc_pkg::CTRL_ADDR, 16'h0047);
        rdchk("ctrl locked", osc_pkg::CTRL_ADDR, 16'h3300);
        chk("pin freeze locked", 16'h0000, {15'h0, pin_map_frozen});
        $display("done lock");
    endtask

    // sleep-run and crystal bits, read-only current field, zero bits
    task automatic t_bits();
        uwr(16'hF816);
        rdchk("ctrl bits", osc_pkg::CTRL_ADDR, 16'h3006);
        chk("crystal on", 16'h0001, {15'h0, low_speed_crystal_on});
        sleep_mode <= 1'b1;
        cyc(3);
        chk("primary asleep run", 16'h0001, {15'h0, primary_osc_run});
        uwr(16'h0300);
        cyc(3);
        chk("primary asleep stop", 16'h0000, {15'h0, primary_osc_run});
        chk("crystal off", 16'h0000, {15'h0, low_speed_crystal_on});
        sleep_mode <= 1'b0;
        $display("done bits");
    endtask

    // lock status, switches to pll and non-pll sources, reserved code
    task automatic t_switch();
        int s0;
        // start-up timer alone is enough for the lock bit
        pll_startup_done <= 1'b1;
        cyc(6);
        rdchk("lock timer", osc_pkg::CTRL_ADDR, 16'h3320);
        pll_startup_done <= 1'b0;
        pll_in_lock <= 1'b1;
        cyc(6);
        rdchk("lock pll source", osc_pkg::CTRL_ADDR, 16'h3320);
        s0 = n_starts;
        uwr(16'h0101);
        cyc(2);
        chk("one start", 16'(s0 + 1), 16'(n_starts));
        chk("target", {13'h0, osc_pkg::SRC_FRCPLL}, {13'h0, switch_target});
        rdchk("ctrl busy", osc_pkg::CTRL_ADDR, 16'h3101);
        done_pulse();
        chk("current", {13'h0, osc_pkg::SRC_FRCPLL}, {13'h0, current_source});
        rdchk("ctrl switched", osc_pkg::CTRL_ADDR, 16'h1120);
        uwr(16'h0501);
        done_pulse();
        rdchk("ctrl non-pll", osc_pkg::CTRL_ADDR, 16'h5500);
        s0 = n_starts;
        uwr(16'h0601);
        cyc(3);
        chk("reserved no start", 16'(s0), 16'(n_starts));
        rdchk("ctrl reserved", osc_pkg::CTRL_ADDR, 16'h5600);
        $display("done switch");
    endtask

    // failure flag sets from the monitor, clears only under unlock
    task automatic t_fail();
        fail_safe_monitor_fail <= 1'b1;
        cyc(4);
        fail_safe_monitor_fail <= 1'b0;
        cyc(4);
        wr(osc_pkg::CTRL_ADDR, 16'h0600);
        rdchk("fail set", osc_pkg::CTRL_ADDR, 16'h5608);
        uwr(16'h0600);
        rdchk("fail cleared", osc_pkg::CTRL_ADDR, 16'h5600);
        $display("done fail");
    endtask

    // pin freeze set under unlock, then sticky with the one-way fuse
    task automatic t_pin();
        uwr(16'h0640);
        cyc(0);
        chk("pin set", 16'h0001, {15'h0, pin_map_frozen});
        uwr(16'h0600);
        rdchk("pin sticky", osc_pkg::CTRL_ADDR, 16'h5640);
        $display("done pin");
    endtask

    // clock selection freeze blocks divider, source and request writes
    task automatic t_freeze();
        int s0;
        wr(osc_pkg::DIV_ADDR, 16'h00E0);
        rdchk("divider", osc_pkg::DIV_ADDR, 16'h00E0);
        uwr(16'h06C0);
        cyc(1);
        chk("frozen", 16'h0001, {15'h0, clock_select_frozen});
        wr(osc_pkg::DIV_ADDR, 16'h0000);
        cyc(1);
        chk("postscaler held", 16'h0003, {14'h0, system_clock_postscaler});
        chk("pll enable held", 16'h0001, {15'h0, pll_enable});
        s0 = n_starts;
        uwr(16'h0141);
        cyc(3);
        chk("frozen no start", 16'(s0), 16'(n_starts));
        rdchk("ctrl frozen", osc_pkg::CTRL_ADDR, 16'h56C0);
        // monitor disabled: the freeze no longer bites
        fail_safe_monitor_enable <= 1'b0;
        wr(osc_pkg::DIV_ADDR, 16'h0000);
        cyc(1);
        chk("unfrozen", 16'h0000, {15'h0, clock_select_frozen});
        chk("postscaler free", 16'h0000, {14'h0, system_clock_postscaler});
        // without the one-way fuse the pin freeze clears again
        one_way_pin_freeze_fuse <= 1'b0;
        uwr(16'h0600);
        rdchk("ctrl released", osc_pkg::CTRL_ADDR, 16'h5600);
        chk("pin released", 16'h0000, {15'h0, pin_map_frozen});
        $display("done freeze");
    endtask

    // verdict and end of run
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // watchdog well beyond the expected run
    initial begin
        #(40 * 5000);
        err_count++;
        tally_and_finish();
    end

    // reset, then the scenarios in order
    initial begin
        reset = 1'b1;
        {reg_write, reg_read, reg_addr, reg_wdata} = '0;
        {pll_in_lock, pll_startup_done, fail_safe_monitor_fail, sleep_mode, switch_done} = '0;
        initial_source_fuses = osc_pkg::SRC_PRIPLL;
        one_way_pin_freeze_fuse = 1'b1;
        fail_safe_monitor_enable = 1'b1;
        repeat (8) @(posedge clk);
        reset <= 1'b0;
        cyc(3);
        t_reset();
        t_lock();
        t_bits();
        t_switch();
        t_fail();
        t_pin();
        t_freeze();
        tally_and_finish();
    end
endmodule
